// File: core/csa_pkg.sv
// Package for the command source arbiter: register map, fields, encodings and carriers.
package csa_pkg;

	// ==========================================================================
	// Register map and bus
	// ==========================================================================
	localparam int unsigned CSA_AXI_AW      = 8;
	localparam logic [7:0]  CSA_OFF_CTRL    = 8'h00;
	localparam logic [7:0]  CSA_OFF_PUSEL   = 8'h04;
	localparam logic [7:0]  CSA_OFF_STATUS  = 8'h08;
	localparam logic [1:0]  CSA_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  CSA_RESP_SLVERR = 2'h2;

	// ==========================================================================
	// Field positions
	// ==========================================================================
	localparam int unsigned CSA_CTRL_START_POS = 0;
	localparam int unsigned CSA_CTRL_FREQ_POS  = 4;
	localparam int unsigned CSA_CTRL_WPS_POS   = 8;
	localparam int unsigned CSA_CTRL_OMS_POS   = 12;
	localparam int unsigned CSA_PUSEL_POS      = 0;
	localparam int unsigned CSA_ST_ACT_POS     = 0;
	localparam int unsigned CSA_ST_ATT_POS     = 16;
	localparam int unsigned CSA_ST_SRC_POS     = 17;
	localparam int unsigned CSA_ST_LAMP_POS    = 19;
	localparam int unsigned CSA_ST_OMS_POS     = 20;

	// ==========================================================================
	// Setting values and reset values
	// ==========================================================================
	localparam logic [13:0] CSA_PUSEL_CONN  = 14'h0002;
	localparam logic [13:0] CSA_PUSEL_PANEL = 14'h0004;
	localparam logic [13:0] CSA_PUSEL_AUTO  = 14'h270F;
	localparam logic        CSA_START_COMM  = 1'b0;
	localparam logic [1:0]  CSA_FREQ_COMM   = 2'h0;
	localparam logic [1:0]  CSA_FREQ_EXT    = 2'h1;
	localparam logic [1:0]  CSA_FREQ_EXT_NF = 2'h2;
	localparam logic [1:0]  CSA_WPS_ALL     = 2'h2;
	localparam logic [2:0]  CSA_OMS_COMB1   = 3'h3;
	localparam logic [2:0]  CSA_OMS_COMB2   = 3'h4;
	localparam logic        CSA_START_RST   = 1'b0;
	localparam logic [1:0]  CSA_FREQ_RST    = 2'h0;
	localparam logic [1:0]  CSA_WPS_RST     = 2'h0;
	localparam logic [2:0]  CSA_OMS_RST     = 3'h0;
	localparam logic [13:0] CSA_PUSEL_RST   = 14'h270F;

	// ==========================================================================
	// Enumerations
	// ==========================================================================
	typedef enum logic [2:0] {
		CSA_MODE_PU    = 3'b000,
		CSA_MODE_EXT   = 3'b001,
		CSA_MODE_COMB1 = 3'b010,
		CSA_MODE_COMB2 = 3'b011,
		CSA_MODE_NET   = 3'b100
	} csa_mode_t;

	typedef enum logic [2:0] {
		CSA_CMD_READ   = 3'b000,
		CSA_CMD_START  = 3'b001,
		CSA_CMD_STOP   = 3'b010,
		CSA_CMD_FREQ   = 3'b011,
		CSA_CMD_PWRITE = 3'b100,
		CSA_CMD_PCLEAR = 3'b101,
		CSA_CMD_RESET  = 3'b110
	} csa_kind_t;

	typedef enum logic [1:0] {
		CSA_SRC_TERM  = 2'b00,
		CSA_SRC_RS485 = 2'b01,
		CSA_SRC_UNIT  = 2'b10,
		CSA_SRC_PANEL = 2'b11
	} csa_src_t;

	// ==========================================================================
	// Carriers
	// ==========================================================================
	typedef struct packed {
		logic        valid;
		csa_kind_t   kind;
		logic        pu_stop;
		logic        modbus;
		logic        from_t2;
		logic        multispeed;
		logic        t4_au;
		logic        always_wr;
		logic [15:0] data;
	} csa_cmd_t;

	typedef struct packed {
		logic        valid;
		csa_src_t    src;
		csa_kind_t   kind;
		logic [15:0] data;
	} csa_issue_t;

	typedef struct packed {
		logic       start_sel;
		logic [1:0] freq_sel;
		logic [1:0] wps;
		logic [2:0] oms;
	} csa_cfg_t;

	typedef struct packed {
		csa_cfg_t              cfg;
		logic [13:0]           pusel_pend;
		logic [13:0]           pusel_act;
		logic [2:0]            oms_act;
		logic                  att_s1;
		logic                  att_s2;
		logic                  aw_have;
		logic                  w_have;
		logic [CSA_AXI_AW-1:0] aw_addr;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
		csa_issue_t            issue;
		logic                  lamps;
	} csa_state_t;

endpackage : csa_pkg

// File: core/csa_arbiter.sv
// Command source arbiter: decides which source may start, stop, set, write and reset.
`timescale 1ns/1ps

module csa_arbiter (
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	// AXI4-Lite write address and data
	input  wire logic [csa_pkg::CSA_AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [csa_pkg::CSA_AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Operation mode from the mode selection logic
	input  wire csa_pkg::csa_mode_t          op_mode_in,
	input  wire logic                        comm_error,
	input  wire logic                        pu_attached_pin,
	// Mode change request into Network mode
	input  wire logic                        net_mode_req,
	output logic                             net_mode_ok,
	// Commands, one slot per source, indexed by csa_src_t
	input  wire csa_pkg::csa_cmd_t [3:0]     cmd_in,
	output logic [3:0]                       cmd_accept,
	output logic [3:0]                       cmd_refuse,
	// Arbitrated results
	output csa_pkg::csa_issue_t              cmd_issue,
	output logic                             panel_lamps_on,
	output logic [13:0]                      pusel_active,
	output csa_pkg::csa_mode_t               mode_effective
);

	// ==========================================================================
	// Helpers
	// ==========================================================================
	// Byte-lane merge so that partial writes keep the other bytes
	function automatic logic [31:0] csa_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : csa_merge

	// Authority of one source for one command under the present settings
	function automatic logic csa_allowed(input csa_pkg::csa_src_t src,
			input csa_pkg::csa_cmd_t c, input csa_pkg::csa_mode_t m,
			input logic conn_sel, input csa_pkg::csa_src_t pu_src,
			input csa_pkg::csa_cfg_t cfg, input logic cerr);
		logic pu;
		logic ext;
		logic c1;
		logic c2;
		logic net;
		logic own;
		logic st;
		logic sp;
		logic fq;
		logic wr;
		logic rs;
		logic res;
		pu  = (m == csa_pkg::CSA_MODE_PU);
		ext = (m == csa_pkg::CSA_MODE_EXT);
		c1  = (m == csa_pkg::CSA_MODE_COMB1);
		c2  = (m == csa_pkg::CSA_MODE_COMB2);
		net = (m == csa_pkg::CSA_MODE_NET);
		own = (src == pu_src);
		st  = 1'b0;
		sp  = 1'b0;
		fq  = 1'b0;
		wr  = 1'b0;
		rs  = 1'b0;
		unique case (src)
			csa_pkg::CSA_SRC_TERM: begin
				st = ext | c1 | (net & (cfg.start_sel != csa_pkg::CSA_START_COMM));
				sp = st;
				fq = ext | c2 | (c1 & (c.multispeed | c.t4_au))
					| (net & (cfg.freq_sel == csa_pkg::CSA_FREQ_EXT))
					| (net & (cfg.freq_sel == csa_pkg::CSA_FREQ_EXT_NF) & ~c.from_t2);
				rs = 1'b1;
			end
			csa_pkg::CSA_SRC_RS485: begin
				if (conn_sel) begin
					st = pu | c2;
					sp = pu | c2 | ((ext | c1) & c.pu_stop);
					fq = pu | c1;
					wr = pu | c1 | c2;
					rs = ~net & ~cerr;
				end else begin
					st = net & (cfg.start_sel == csa_pkg::CSA_START_COMM);
					sp = st;
					fq = net & (cfg.freq_sel != csa_pkg::CSA_FREQ_EXT);
					wr = net;
					rs = net & ~cerr;
				end
				// Modbus framing only works from Network mode
				if (c.modbus && (conn_sel || !net)) begin
					st = 1'b0;
					sp = 1'b0;
					fq = 1'b0;
					wr = 1'b0;
					rs = 1'b0;
				end
			end
			default: begin
				// Panel or parameter unit act only while they hold PU source
				st = own & (pu | c2);
				sp = own & (pu | c2 | ((ext | c1) & c.pu_stop));
				fq = own & (pu | c1);
				wr = own & (pu | c1 | c2);
				rs = own & ~net;
			end
		endcase
		unique case (c.kind)
			csa_pkg::CSA_CMD_READ:   res = 1'b1;
			csa_pkg::CSA_CMD_START:  res = st;
			csa_pkg::CSA_CMD_STOP:   res = sp;
			csa_pkg::CSA_CMD_FREQ:   res = fq;
			csa_pkg::CSA_CMD_PWRITE: res = wr | c.always_wr | (cfg.wps == csa_pkg::CSA_WPS_ALL);
			csa_pkg::CSA_CMD_PCLEAR: res = wr;
			csa_pkg::CSA_CMD_RESET:  res = rs;
			default:                 res = 1'b0;
		endcase
		return res;
	endfunction : csa_allowed

	// ==========================================================================
	// State
	// ==========================================================================
	csa_pkg::csa_state_t s_q;
	csa_pkg::csa_state_t s_d;

	csa_pkg::csa_mode_t  mode;
	csa_pkg::csa_src_t   pu_src;
	logic                conn_sel;
	logic [3:0]          allowed;
	logic [3:0]          grant;
	logic                aw_hs;
	logic                w_hs;
	logic                ar_hs;
	logic [31:0]         ctrl_img;
	logic [31:0]         pusel_img;
	logic [31:0]         status_img;
	logic [31:0]         wr_word;

	// ==========================================================================
	// Arbitration, combinational
	// ==========================================================================
	// Latched operation mode select forces the combined modes
	always_comb begin
		if (s_q.oms_act == csa_pkg::CSA_OMS_COMB1) begin
			mode = csa_pkg::CSA_MODE_COMB1;
		end else if (s_q.oms_act == csa_pkg::CSA_OMS_COMB2) begin
			mode = csa_pkg::CSA_MODE_COMB2;
		end else begin
			mode = op_mode_in;
		end
	end

	// PU-mode source from the active select; link traffic plays no part
	always_comb begin
		conn_sel = (s_q.pusel_act == csa_pkg::CSA_PUSEL_CONN);
		if (conn_sel) begin
			pu_src = csa_pkg::CSA_SRC_RS485;
		end else if (s_q.pusel_act == csa_pkg::CSA_PUSEL_PANEL) begin
			pu_src = csa_pkg::CSA_SRC_PANEL;
		end else if (s_q.att_s2) begin
			pu_src = csa_pkg::CSA_SRC_UNIT;
		end else begin
			pu_src = csa_pkg::CSA_SRC_PANEL;
		end
	end

	// Judge every slot; terminals win ties, others wait without refusal
	always_comb begin
		logic taken;
		taken = 1'b0;
		for (int i = 0; i < 4; i++) begin
			allowed[i] = csa_allowed(csa_pkg::csa_src_t'(i[1:0]), cmd_in[i], mode, conn_sel,
				pu_src, s_q.cfg, comm_error);
			grant[i]   = cmd_in[i].valid & allowed[i] & ~taken;
			taken      = taken | grant[i];
		end
	end

	assign cmd_accept  = grant;
	assign cmd_refuse  = {cmd_in[3].valid, cmd_in[2].valid, cmd_in[1].valid,
		cmd_in[0].valid} & ~allowed;
	assign net_mode_ok = net_mode_req & ~conn_sel;

	// ==========================================================================
	// Register images and bus handshakes
	// ==========================================================================
	always_comb begin
		ctrl_img = 32'h0000_0000;
		ctrl_img[csa_pkg::CSA_CTRL_START_POS] = s_q.cfg.start_sel;
		ctrl_img[csa_pkg::CSA_CTRL_FREQ_POS +: 2] = s_q.cfg.freq_sel;
		ctrl_img[csa_pkg::CSA_CTRL_WPS_POS +: 2]  = s_q.cfg.wps;
		ctrl_img[csa_pkg::CSA_CTRL_OMS_POS +: 3]  = s_q.cfg.oms;
		pusel_img = 32'h0000_0000;
		pusel_img[csa_pkg::CSA_PUSEL_POS +: 14] = s_q.pusel_pend;
		status_img = 32'h0000_0000;
		status_img[csa_pkg::CSA_ST_ACT_POS +: 14] = s_q.pusel_act;
		status_img[csa_pkg::CSA_ST_ATT_POS]       = s_q.att_s2;
		status_img[csa_pkg::CSA_ST_SRC_POS +: 2]  = pu_src;
		status_img[csa_pkg::CSA_ST_LAMP_POS]      = s_q.lamps;
		status_img[csa_pkg::CSA_ST_OMS_POS +: 3]  = s_q.oms_act;
	end

	assign s_axi_awready = ~s_q.aw_have & ~s_q.bvalid;
	assign s_axi_wready  = ~s_q.w_have & ~s_q.bvalid;
	assign s_axi_arready = ~s_q.rvalid;
	assign aw_hs         = s_axi_awvalid & s_axi_awready;
	assign w_hs          = s_axi_wvalid & s_axi_wready;
	assign ar_hs         = s_axi_arvalid & s_axi_arready;

	// ==========================================================================
	// Next state
	// ==========================================================================
	always_comb begin
		s_d = s_q;
		// Pin passes two flops before anything reads it
		s_d.att_s1 = pu_attached_pin;
		s_d.att_s2 = s_q.att_s1;
		s_d.lamps  = (pu_src == csa_pkg::CSA_SRC_PANEL);

		// Write channel: address and data may come in either order
		if (aw_hs) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (w_hs) begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.aw_have && s_q.w_have) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = csa_pkg::CSA_RESP_OKAY;
			unique case (s_q.aw_addr)
				csa_pkg::CSA_OFF_CTRL: begin
					wr_word = csa_merge(ctrl_img, s_q.w_data, s_q.w_strb);
					s_d.cfg.start_sel = wr_word[csa_pkg::CSA_CTRL_START_POS];
					s_d.cfg.freq_sel  = wr_word[csa_pkg::CSA_CTRL_FREQ_POS +: 2];
					s_d.cfg.wps       = wr_word[csa_pkg::CSA_CTRL_WPS_POS +: 2];
					s_d.cfg.oms       = wr_word[csa_pkg::CSA_CTRL_OMS_POS +: 3];
				end
				csa_pkg::CSA_OFF_PUSEL: begin
					// No lock of any kind guards this one
					wr_word = csa_merge(pusel_img, s_q.w_data, s_q.w_strb);
					s_d.pusel_pend = wr_word[csa_pkg::CSA_PUSEL_POS +: 14];
				end
				csa_pkg::CSA_OFF_STATUS: begin
					wr_word = 32'h0000_0000;
				end
				default: begin
					wr_word   = 32'h0000_0000;
					s_d.bresp = csa_pkg::CSA_RESP_SLVERR;
				end
			endcase
		end else begin
			wr_word = 32'h0000_0000;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		// Read channel
		if (ar_hs) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = csa_pkg::CSA_RESP_OKAY;
			unique case (s_axi_araddr)
				csa_pkg::CSA_OFF_CTRL:   s_d.rdata = ctrl_img;
				csa_pkg::CSA_OFF_PUSEL:  s_d.rdata = pusel_img;
				csa_pkg::CSA_OFF_STATUS: s_d.rdata = status_img;
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.rresp = csa_pkg::CSA_RESP_SLVERR;
				end
			endcase
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// Issued command is a one-cycle record of the granted slot
		s_d.issue.valid = |grant;
		s_d.issue.src   = csa_pkg::CSA_SRC_TERM;
		s_d.issue.kind  = csa_pkg::CSA_CMD_READ;
		s_d.issue.data  = 16'h0000;
		for (int i = 3; i >= 0; i--) begin
			if (grant[i]) begin
				s_d.issue.src  = csa_pkg::csa_src_t'(i[1:0]);
				s_d.issue.kind = cmd_in[i].kind;
				s_d.issue.data = cmd_in[i].data;
			end
		end

		// Device reset reloads the latched selects; until then old ones hold
		if (|grant && s_d.issue.kind == csa_pkg::CSA_CMD_RESET) begin
			s_d.pusel_act = s_d.pusel_pend;
			s_d.oms_act   = s_d.cfg.oms;
		end

		// Synchronous power-on reset: every flop takes a constant
		if (!rst_n) begin
			s_d               = '0;
			s_d.cfg.start_sel = csa_pkg::CSA_START_RST;
			s_d.cfg.freq_sel  = csa_pkg::CSA_FREQ_RST;
			s_d.cfg.wps       = csa_pkg::CSA_WPS_RST;
			s_d.cfg.oms       = csa_pkg::CSA_OMS_RST;
			s_d.pusel_pend    = csa_pkg::CSA_PUSEL_RST;
			s_d.pusel_act     = csa_pkg::CSA_PUSEL_RST;
			s_d.oms_act       = csa_pkg::CSA_OMS_RST;
		end
	end

	// ==========================================================================
	// State register
	// ==========================================================================
	always_ff @(posedge clk_sys) begin
		s_q <= s_d;
	end

	// Outputs
	assign s_axi_bvalid   = s_q.bvalid;
	assign s_axi_bresp    = s_q.bresp;
	assign s_axi_rvalid   = s_q.rvalid;
	assign s_axi_rresp    = s_q.rresp;
	assign s_axi_rdata    = s_q.rdata;
	assign cmd_issue      = s_q.issue;
	assign panel_lamps_on = s_q.lamps;
	assign pusel_active   = s_q.pusel_act;
	assign mode_effective = mode;

endmodule : csa_arbiter

// File: tb/csa_src_model.sv
// Model of the command sources that stand at the arbiter's four slots.
`timescale 1ns/1ps
// ==========================================================================
// Command source model
// ==========================================================================
module csa_src_model (
	// Clock
	input  wire logic                    clk_sys,
	// Requests from the bench
	input  wire logic [3:0]              go,
	input  wire csa_pkg::csa_cmd_t [3:0] req,
	// Arbiter answers
	input  wire logic [3:0]              cmd_accept,
	input  wire logic [3:0]              cmd_refuse,
	// Slots driven into the arbiter
	output csa_pkg::csa_cmd_t [3:0]      cmd_in
);
	initial cmd_in = '0;
	// Hold a command until judged; a released slot shows scrambled bits, not the old value
	always @(posedge clk_sys) begin
		for (int i = 0; i < 4; i++) begin
			if (go[i])
				cmd_in[i] <= req[i];
			else if (cmd_in[i].valid && (cmd_accept[i] || cmd_refuse[i]))
				cmd_in[i] <= {1'b0, ~cmd_in[i][24:0]};
		end
	end
endmodule : csa_src_model

// File: tb/csa_arbiter_sva.sv
// Checker for the command source arbiter, bound to its ports.
`timescale 1ns/1ps
// ==========================================================================
// Checker
// ==========================================================================
module csa_arbiter_sva (
	// Clock and reset
	input wire logic                    clk_sys,
	input wire logic                    rst_n,
	// Watched ports
	input wire logic                    net_mode_req,
	input wire logic                    net_mode_ok,
	input wire logic                    comm_error,
	input wire csa_pkg::csa_cmd_t [3:0] cmd_in,
	input wire logic [3:0]              cmd_accept,
	input wire logic [3:0]              cmd_refuse,
	input wire csa_pkg::csa_issue_t     cmd_issue,
	input wire logic                    panel_lamps_on,
	input wire logic [13:0]             pusel_active,
	input wire csa_pkg::csa_mode_t      mode_effective
);
	// One clock domain, so defaults are shared
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Shorthands for the link slot and the connector select
	csa_pkg::csa_cmd_t rs;
	logic              s2;
	assign rs = cmd_in[1];
	assign s2 = pusel_active == csa_pkg::CSA_PUSEL_CONN;
	property p_net; net_mode_req && s2 |-> !net_mode_ok; endproperty
	a_net: assert property (p_net) else $error("network mode granted");
	property p_lamp; s2 |=> !panel_lamps_on; endproperty
	a_lamp: assert property (p_lamp) else $error("lamps lit");
	property p_start; rs.valid && rs.kind == csa_pkg::CSA_CMD_START && s2
		&& mode_effective inside {csa_pkg::CSA_MODE_EXT, csa_pkg::CSA_MODE_COMB1,
		csa_pkg::CSA_MODE_NET} |-> cmd_refuse[1]; endproperty
	a_start: assert property (p_start) else $error("link start taken");
	property p_freq; rs.valid && rs.kind == csa_pkg::CSA_CMD_FREQ && s2
		&& mode_effective inside {csa_pkg::CSA_MODE_EXT, csa_pkg::CSA_MODE_COMB2,
		csa_pkg::CSA_MODE_NET} |-> cmd_refuse[1]; endproperty
	a_freq: assert property (p_freq) else $error("link frequency taken");
	property p_other; rs.valid && !s2 && mode_effective != csa_pkg::CSA_MODE_NET
		&& rs.kind inside {csa_pkg::CSA_CMD_START, csa_pkg::CSA_CMD_STOP,
		csa_pkg::CSA_CMD_FREQ} |-> cmd_refuse[1]; endproperty
	a_other: assert property (p_other) else $error("link command outside network");
	property p_cerr; rs.valid && rs.kind == csa_pkg::CSA_CMD_RESET && comm_error
		|-> cmd_refuse[1] && !cmd_accept[1]; endproperty
	a_cerr: assert property (p_cerr) else $error("reset on comm error");
	property p_read; rs.valid && rs.kind == csa_pkg::CSA_CMD_READ |-> !cmd_refuse[1]; endproperty
	a_read: assert property (p_read) else $error("read refused");
	property p_trst; cmd_in[0].valid && cmd_in[0].kind == csa_pkg::CSA_CMD_RESET
		|-> cmd_accept[0]; endproperty
	a_trst: assert property (p_trst) else $error("terminal reset refused");
	property p_grant; $onehot0(cmd_accept) && (cmd_accept & cmd_refuse) == 4'h0; endproperty
	a_grant: assert property (p_grant) else $error("grant clash");
	property p_issue; |cmd_accept |=> cmd_issue.valid; endproperty
	a_issue: assert property (p_issue) else $error("grant not issued");
	property p_quiet; !(|cmd_accept) |=> !cmd_issue.valid; endproperty
	a_quiet: assert property (p_quiet) else $error("issue without grant");
endmodule : csa_arbiter_sva

bind csa_arbiter csa_arbiter_sva u_sva (.*);

// File: tb/test_command_source_arbiter.sv
// Self-checking bench for the command source arbiter.
`timescale 1ns/1ps
// ==========================================================================
// Bench
// ==========================================================================
module test_command_source_arbiter;
	logic clk_sys = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, comm_error = 0, pu_attached_pin = 0;
	logic net_mode_req = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, net_mode_ok, panel_lamps_on;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = 0, go = 0, cmd_accept, cmd_refuse;
	logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
	logic [13:0] pusel_active;
	csa_pkg::csa_mode_t op_mode_in = csa_pkg::CSA_MODE_PU, mode_effective;
	csa_pkg::csa_cmd_t [3:0] cmd_in, req = '0;
	csa_pkg::csa_issue_t cmd_issue;
	int bad_count = 0, total_checks = 0;
	int kl[7] = '{0, 1, 2, 3, 4, 5, 6};
	// Bench copies of start, frequency and write selects, and the Modbus flag
	int ss = 0, fs = 0, wp = 0;
	bit mb = 0;
	csa_arbiter dut_u (.*);
	csa_src_model u_src (.*);
	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// Write with address and data offered together, each released when taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, csa_pkg::CSA_RESP_OKAY);
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		rrsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// Expected judgement; slot 0 terminals, slot 1 link, modes PU EXT C1 C2 NET
	function automatic bit ok(input int s, input int k, input int m, input bit s2);
		if (k == 0) return 1'b1;
		if (k == 4 && wp == 2) return 1'b1;
		if (s == 1 && mb && (s2 || m != 4)) return 1'b0;
		if (s == 0 && k == 6) return 1'b1;
		if (s == 0 && k == 3) return m == 1 || m == 3 || (m == 4 && fs != 0);
		if (s == 0 && k > 3) return 1'b0;
		if (s == 0) return m == 1 || m == 2 || (m == 4 && ss == 1);
		if (k == 6 && comm_error) return 1'b0;
		if (!s2) return m == 4 && !(k < 3 && ss == 1) && !(k == 3 && fs == 1);
		if (k == 6) return m != 4;
		if (k > 3) return m != 1 && m != 4;
		if (k == 3) return m == 0 || m == 2;
		return m == 0 || m == 3;
	endfunction : ok
	// One command through the partner, judged then followed to its issue pulse
	task send(input int s, input int k, input int m, input bit s2);
		logic [15:0] d;
		bit a;
		d = 16'($urandom);
		a = ok(s, k, m, s2);
		@(posedge clk_sys);
		req[s] <= '{valid: 1'b1, kind: csa_pkg::csa_kind_t'(k), modbus: mb,
			data: d, default: '0};
		go[s] <= 1'b1;
		@(posedge clk_sys);
		go[s] <= 1'b0;
		#1;
		chk(cmd_accept[s], a);
		chk(cmd_refuse[s], !a);
		@(posedge clk_sys);
		#1;
		if (a) chk(cmd_issue, {1'b1, s[1:0], k[2:0], d});
		else chk(cmd_issue.valid, 1'b0);
	endtask : send
	// Every mode against every kind from terminals and link
	task sweep(input bit s2);
		for (int m = 0; m < 5; m++) begin
			@(posedge clk_sys);
			op_mode_in <= csa_pkg::csa_mode_t'(m);
			for (int s = 0; s < 2; s++)
				for (int i = 0; i < 7; i++)
					send(s, kl[i], m, s2);
		end
	endtask : sweep
	// Main sequence
	initial begin
		rdat = $urandom(32'h636cf67c);
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(csa_pkg::CSA_OFF_PUSEL);
		chk(rdat, 32'h0000270F);
		rd(8'hFC);
		chk(rrsp, csa_pkg::CSA_RESP_SLVERR);
		chk(rdat, 32'h0);
		chk(panel_lamps_on, 1'b1);
		pu_attached_pin <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk(panel_lamps_on, 1'b0);
		pu_attached_pin <= 1'b0;
		repeat (5) @(posedge clk_sys);
		sweep(1'b0);
		// Start external, frequency external with comm valid, write select 2
		wr(csa_pkg::CSA_OFF_CTRL, 32'h0000_0221);
		ss = 1;
		fs = 2;
		wp = 2;
		rd(csa_pkg::CSA_OFF_CTRL);
		chk(rdat, 32'h0000_0221);
		sweep(1'b0);
		wr(csa_pkg::CSA_OFF_CTRL, 32'h0);
		ss = 0;
		fs = 0;
		wp = 0;
		net_mode_req <= 1'b1;
		wr(csa_pkg::CSA_OFF_PUSEL, 32'h2);
		chk(net_mode_ok, 1'b1);
		chk(pusel_active, 32'h270F);
		rd(csa_pkg::CSA_OFF_PUSEL);
		chk(rdat, 32'h2);
		send(0, 6, 4, 1'b0);
		repeat (2) @(posedge clk_sys);
		chk(pusel_active, 32'h2);
		chk(net_mode_ok, 1'b0);
		chk(panel_lamps_on, 1'b0);
		sweep(1'b1);
		// Modbus framing on the link while the connector holds the PU source
		mb = 1'b1;
		sweep(1'b1);
		mb = 1'b0;
		comm_error <= 1'b1;
		op_mode_in <= csa_pkg::CSA_MODE_PU;
		@(posedge clk_sys);
		send(1, 6, 0, 1'b1);
		// Operation mode select 3 waits for a device reset, then forces combined 1
		wr(csa_pkg::CSA_OFF_CTRL, 32'h0000_3000);
		chk(mode_effective, csa_pkg::CSA_MODE_PU);
		send(0, 6, 0, 1'b1);
		chk(mode_effective, csa_pkg::CSA_MODE_COMB1);
		send(1, 3, 2, 1'b1);
		results();
	end
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		results();
	end
endmodule : test_command_source_arbiter
